// ===== verilog/memory_map_pkg.sv
// Purpose: shared constants and types for the memory map address decoder
// Assumes: 16-bit program and data spaces, word addressed
// Notes:   control bits live in a register reached over AHB-Lite
//
// Functional notes
// - placement 1: program FE00-FEFF and FF00-FFFF both reach block zero.
// - placement 0: data 0100-01FF and 0200-02FF both reach block zero.
// - data 0300-03FF and 0400-04FF always reach block one.
// - program words 0040-0043 hold the security password, not user code.
// - vectors sit at program 0000-003F; user code starts at 0044.
// - boot ROM enabled: program 0000-00FF goes to boot ROM.
// - mode select 0 sends low program space to flash, 1 to external.
// - program 8000-87FF is single-access RAM if enabled, else external bus.
// - data 0800-0FFF is single-access RAM if enabled, else reserved.
package memory_map_pkg;

   // -------------------------------------------------------------------
   // access targets
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      TGT_NONE   = 4'h0,
      TGT_FLASH  = 4'h1,
      TGT_EXT    = 4'h2,
      TGT_BOOT   = 4'h3,
      TGT_B0     = 4'h4,
      TGT_B1     = 4'h5,
      TGT_B2     = 4'h6,
      TGT_SINGLE_ACCESS_RAM  = 4'h7,
      TGT_MMR    = 4'h8,
      TGT_PERIPH = 4'h9
   } target_t;

   // -------------------------------------------------------------------
   // address boundaries
   // -------------------------------------------------------------------
   localparam logic [15:0] P_VEC_END   = 16'h003F;
   localparam logic [15:0] P_PWD_LO    = 16'h0040;
   localparam logic [15:0] P_PWD_HI    = 16'h0043;
   localparam logic [15:0] P_USER_LO   = 16'h0044;
   localparam logic [15:0] P_BOOT_END  = 16'h00FF;
   localparam logic [15:0] P_FLASH_END = 16'h7FFF;
   localparam logic [15:0] P_SINGLE_ACCESS_RAM_LO  = 16'h8000;
   localparam logic [15:0] P_SINGLE_ACCESS_RAM_HI  = 16'h87FF;
   localparam logic [15:0] P_B0_ALIAS  = 16'hFE00;

   localparam logic [15:0] D_MMR_END   = 16'h005F;
   localparam logic [15:0] D_B2_LO     = 16'h0060;
   localparam logic [15:0] D_B2_HI     = 16'h007F;
   localparam logic [15:0] D_B0_LO     = 16'h0100;
   localparam logic [15:0] D_B0_HI     = 16'h02FF;
   localparam logic [15:0] D_B0_MAIN   = 16'h0200;
   localparam logic [15:0] D_B1_LO     = 16'h0300;
   localparam logic [15:0] D_B1_HI     = 16'h04FF;
   localparam logic [15:0] D_SINGLE_ACCESS_RAM_LO  = 16'h0800;
   localparam logic [15:0] D_SINGLE_ACCESS_RAM_HI  = 16'h0FFF;
   localparam logic [15:0] D_PERIPH_LO = 16'h7000;
   localparam logic [15:0] D_PERIPH_HI = 16'h7FFF;
   localparam logic [15:0] D_EXT_LO    = 16'h8000;

   // -------------------------------------------------------------------
   // register map (byte addresses) and control field positions
   // -------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_HIT_COUNT = 8'h04;
   localparam logic [7:0] REG_HIT_ADDR  = 8'h08;

   localparam int CTRL_PLACEMENT = 0;
   localparam int CTRL_PROG_SRAM = 1;
   localparam int CTRL_DATA_SRAM = 2;
   localparam int CTRL_MP_MODE   = 3;
   localparam int CTRL_BOOT_EN   = 4;
   localparam int CTRL_W         = 5;

   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

endpackage : memory_map_pkg

// ===== verilog/space_decode.sv
// Purpose: combinational decode of one address space into a target and offset
// Assumes: IS_PROG selects program-space map, else data-space map
// Notes:   offset is the word index inside block and single-access RAM targets, else the full address

`timescale 1ns/10ps

module space_decode #(
   parameter bit IS_PROG = 1'b1
) (
   input  wire logic [15:0]            i_addr,
   input  wire logic                   i_block_zero_placement,
   input  wire logic                   i_program_sram_enable,
   input  wire logic                   i_data_sram_enable,
   input  wire logic                   i_microprocessor_mode_select,
   input  wire logic                   i_boot_enable,
   output memory_map_pkg::target_t     o_target,
   output logic      [15:0]            o_offset,
   output logic                        o_vector,
   output logic                        o_password
);

   always_comb begin
      o_target   = memory_map_pkg::TGT_NONE;
      o_offset   = i_addr;
      o_vector   = 1'b0;
      o_password = 1'b0;
      if (IS_PROG) begin
         o_vector   = (i_addr <= memory_map_pkg::P_VEC_END);
         o_password = (i_addr >= memory_map_pkg::P_PWD_LO) &&
                      (i_addr <= memory_map_pkg::P_PWD_HI);
         if (i_addr <= memory_map_pkg::P_FLASH_END) begin
            if (i_boot_enable && i_addr <= memory_map_pkg::P_BOOT_END) begin
               o_target = memory_map_pkg::TGT_BOOT;
            end else if (i_microprocessor_mode_select) begin
               o_target = memory_map_pkg::TGT_EXT;
            end else begin
               o_target = memory_map_pkg::TGT_FLASH;
            end
         end else if (i_addr >= memory_map_pkg::P_SINGLE_ACCESS_RAM_LO &&
                      i_addr <= memory_map_pkg::P_SINGLE_ACCESS_RAM_HI) begin
            if (i_program_sram_enable) begin
               o_target = memory_map_pkg::TGT_SINGLE_ACCESS_RAM;
               o_offset = {5'h00, i_addr[10:0]};
            end else begin
               o_target = memory_map_pkg::TGT_EXT;
            end
         end else if (i_addr >= memory_map_pkg::P_B0_ALIAS && i_block_zero_placement) begin
            // both 256-word halves fold onto the same block word
            o_target = memory_map_pkg::TGT_B0;
            o_offset = {8'h00, i_addr[7:0]};
         end else begin
            o_target = memory_map_pkg::TGT_EXT;
         end
      end else begin
         if (i_addr <= memory_map_pkg::D_MMR_END) begin
            o_target = memory_map_pkg::TGT_MMR;
         end else if (i_addr >= memory_map_pkg::D_B2_LO &&
                      i_addr <= memory_map_pkg::D_B2_HI) begin
            o_target = memory_map_pkg::TGT_B2;
            o_offset = {11'h000, i_addr[4:0]};
         end else if (i_addr >= memory_map_pkg::D_B0_LO &&
                      i_addr <= memory_map_pkg::D_B0_HI) begin
            // with placement 1 block zero belongs to program space
            if (!i_block_zero_placement) begin
               o_target = memory_map_pkg::TGT_B0;
               o_offset = {8'h00, i_addr[7:0]};
            end
         end else if (i_addr >= memory_map_pkg::D_B1_LO &&
                      i_addr <= memory_map_pkg::D_B1_HI) begin
            o_target = memory_map_pkg::TGT_B1;
            o_offset = {8'h00, i_addr[7:0]};
         end else if (i_addr >= memory_map_pkg::D_SINGLE_ACCESS_RAM_LO &&
                      i_addr <= memory_map_pkg::D_SINGLE_ACCESS_RAM_HI) begin
            if (i_data_sram_enable) begin
               o_target = memory_map_pkg::TGT_SINGLE_ACCESS_RAM;
               o_offset = {5'h00, i_addr[10:0]};
            end
         end else if (i_addr >= memory_map_pkg::D_PERIPH_LO &&
                      i_addr <= memory_map_pkg::D_PERIPH_HI) begin
            o_target = memory_map_pkg::TGT_PERIPH;
         end else if (i_addr >= memory_map_pkg::D_EXT_LO) begin
            o_target = memory_map_pkg::TGT_EXT;
         end
      end
   end

endmodule : space_decode

// ===== verilog/memory_map_decoder.sv
// Purpose: steer core program and data accesses to memory targets
// Assumes: one access per space per cycle, result registered one cycle later
// Notes:   control bits set over AHB-Lite; zero wait states, always OKAY

`timescale 1ns/10ps

module memory_map_decoder #(
   parameter logic MP_MODE_RESET = 1'b0
) (
   input  wire logic                   i_clock,
   input  wire logic                   i_rst,
   // ahb-lite slave
   input  wire logic                   hsel,
   input  wire logic [31:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic      [31:0]            hrdata,
   // program space
   input  wire logic                   i_prog_req,
   input  wire logic [15:0]            i_prog_addr,
   input  wire logic                   i_prog_write,
   output logic                        o_prog_valid,
   output memory_map_pkg::target_t     o_prog_target,
   output logic      [15:0]            o_prog_offset,
   output logic                        o_prog_write_en,
   output logic                        o_prog_vector,
   output logic                        o_prog_password,
   // data space
   input  wire logic                   i_data_req,
   input  wire logic [15:0]            i_data_addr,
   input  wire logic                   i_data_write,
   output logic                        o_data_valid,
   output memory_map_pkg::target_t     o_data_target,
   output logic      [15:0]            o_data_offset,
   output logic                        o_data_write_en
);

   // -------------------------------------------------------------------
   // control register and bus slave
   // -------------------------------------------------------------------
   logic [memory_map_pkg::CTRL_W-1:0] ctrl_r;
   logic                              wr_pend_r;
   logic [7:0]                        wr_addr_r;
   logic [15:0]                       hit_count_r;
   logic [15:0]                       hit_addr_r;
   logic                              addr_phase;

   assign addr_phase = hsel && htrans[1] && hready;
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr_r <= haddr[7:0];
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_r <= memory_map_pkg::CTRL_RESET;
         ctrl_r[memory_map_pkg::CTRL_MP_MODE] <= 1'b0;
      end else if (wr_pend_r && wr_addr_r == memory_map_pkg::REG_CTRL) begin
         ctrl_r <= hwdata[memory_map_pkg::CTRL_W-1:0];
      end
   end

   // mode select reset value is a parameter, held until the first edge after release, then the register bit takes over
   logic mp_loaded_r;
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         mp_loaded_r <= 1'b0;
      end else begin
         mp_loaded_r <= 1'b1;
      end
   end

   logic mp_mode;
   assign mp_mode = mp_loaded_r ? ctrl_r[memory_map_pkg::CTRL_MP_MODE] : MP_MODE_RESET;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         unique case (haddr[7:0])
            memory_map_pkg::REG_CTRL:
               hrdata <= {27'h000_0000, ctrl_r[4], mp_mode, ctrl_r[2:0]};
            memory_map_pkg::REG_HIT_COUNT: hrdata <= {16'h0000, hit_count_r};
            memory_map_pkg::REG_HIT_ADDR:  hrdata <= {16'h0000, hit_addr_r};
            default:                       hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // decode
   // -------------------------------------------------------------------
   memory_map_pkg::target_t prog_tgt;
   memory_map_pkg::target_t data_tgt;
   logic [15:0]             prog_off;
   logic [15:0]             data_off;
   logic                    prog_vec;
   logic                    prog_pwd;

   space_decode #(.IS_PROG(1'b1)) u_prog (
      .i_addr                       (i_prog_addr),
      .i_block_zero_placement       (ctrl_r[memory_map_pkg::CTRL_PLACEMENT]),
      .i_program_sram_enable        (ctrl_r[memory_map_pkg::CTRL_PROG_SRAM]),
      .i_data_sram_enable           (ctrl_r[memory_map_pkg::CTRL_DATA_SRAM]),
      .i_microprocessor_mode_select (mp_mode),
      .i_boot_enable                (ctrl_r[memory_map_pkg::CTRL_BOOT_EN]),
      .o_target                     (prog_tgt),
      .o_offset                     (prog_off),
      .o_vector                     (prog_vec),
      .o_password                   (prog_pwd)
   );

   space_decode #(.IS_PROG(1'b0)) u_data (
      .i_addr                       (i_data_addr),
      .i_block_zero_placement       (ctrl_r[memory_map_pkg::CTRL_PLACEMENT]),
      .i_program_sram_enable        (ctrl_r[memory_map_pkg::CTRL_PROG_SRAM]),
      .i_data_sram_enable           (ctrl_r[memory_map_pkg::CTRL_DATA_SRAM]),
      .i_microprocessor_mode_select (mp_mode),
      .i_boot_enable                (ctrl_r[memory_map_pkg::CTRL_BOOT_EN]),
      .o_target                     (data_tgt),
      .o_offset                     (data_off),
      .o_vector                     (),
      .o_password                   ()
   );

   // -------------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------------
   // password words and boot ROM are never writable from the core
   logic prog_wr_ok;
   assign prog_wr_ok = i_prog_write && prog_tgt != memory_map_pkg::TGT_NONE &&
                       prog_tgt != memory_map_pkg::TGT_BOOT && !prog_pwd;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_prog_valid    <= 1'b0;
         o_prog_target   <= memory_map_pkg::TGT_NONE;
         o_prog_offset   <= 16'h0000;
         o_prog_write_en <= 1'b0;
         o_prog_vector   <= 1'b0;
         o_prog_password <= 1'b0;
      end else begin
         o_prog_valid    <= i_prog_req;
         o_prog_target   <= i_prog_req ? prog_tgt : memory_map_pkg::TGT_NONE;
         o_prog_offset   <= prog_off;
         o_prog_write_en <= i_prog_req && prog_wr_ok;
         o_prog_vector   <= i_prog_req && prog_vec;
         o_prog_password <= i_prog_req && prog_pwd;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_data_valid    <= 1'b0;
         o_data_target   <= memory_map_pkg::TGT_NONE;
         o_data_offset   <= 16'h0000;
         o_data_write_en <= 1'b0;
      end else begin
         o_data_valid    <= i_data_req;
         o_data_target   <= i_data_req ? data_tgt : memory_map_pkg::TGT_NONE;
         o_data_offset   <= data_off;
         o_data_write_en <= i_data_req && i_data_write &&
                            data_tgt != memory_map_pkg::TGT_NONE;
      end
   end

   // -------------------------------------------------------------------
   // reserved-access log; a hit in the clearing cycle still counts
   // -------------------------------------------------------------------
   logic hit;
   logic clr;
   assign hit = i_data_req && data_tgt == memory_map_pkg::TGT_NONE;
   assign clr = wr_pend_r && wr_addr_r == memory_map_pkg::REG_HIT_COUNT;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         hit_count_r <= 16'h0000;
         hit_addr_r  <= 16'h0000;
      end else begin
         if (hit) begin
            hit_count_r <= (clr ? 16'h0000 : hit_count_r) + 16'h0001;
            hit_addr_r  <= i_data_addr;
         end else if (clr) begin
            hit_count_r <= 16'h0000;
         end
      end
   end

endmodule : memory_map_decoder

// ===== tb/memory_map_decoder_assertions.sv
// Purpose: port-level checks of the memory map decoder
// Assumes: control register at byte 0x00, zero-wait slave, hready tied to hreadyout
// Notes:   keeps its own copy of the control bits, taken from the bus write

`timescale 1ns/10ps

module memory_map_decoder_assertions (
   input wire logic                    i_clock,
   input wire logic                    i_rst,
   input wire logic                    hsel,
   input wire logic [31:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic [31:0]             hwdata,
   input wire logic                    hready,
   input wire logic                    i_prog_req,
   input wire logic [15:0]             i_prog_addr,
   input wire memory_map_pkg::target_t o_prog_target,
   input wire logic [15:0]             o_prog_offset,
   input wire logic                    o_prog_write_en,
   input wire logic                    o_prog_vector,
   input wire logic                    o_prog_password,
   input wire logic                    i_data_req,
   input wire logic [15:0]             i_data_addr,
   input wire memory_map_pkg::target_t o_data_target,
   input wire logic [15:0]             o_data_offset,
   input wire logic                    o_data_write_en
);
   // -------------------------------------------------------------------
   // control shadow and properties
   // -------------------------------------------------------------------
   logic [4:0] ctrl_r;
   logic       wr_r;

   // the shadow changes on the same edge as the real register, so both see one value
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_r <= 5'h00;
         wr_r   <= 1'b0;
      end else begin
         if (wr_r) ctrl_r <= hwdata[4:0];
         if (hready) wr_r <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   AST_PROG_B0_ALIAS: assert property (i_prog_req && i_prog_addr[15:9] == 7'h7F && ctrl_r[0]
      |=> o_prog_target == memory_map_pkg::TGT_B0
      && o_prog_offset == ($past(i_prog_addr) & 16'h00FF))
      else $error("program alias did not reach block zero");
   AST_DATA_B0_ALIAS: assert property (i_data_req && i_data_addr inside {[16'h0100:16'h02FF]}
      && !ctrl_r[0] |=> o_data_target == memory_map_pkg::TGT_B0
      && o_data_offset == ($past(i_data_addr) & 16'h00FF)) else $error("data block zero alias");
   AST_DATA_B1_ALIAS: assert property (i_data_req && i_data_addr inside {[16'h0300:16'h04FF]}
      |=> o_data_target == memory_map_pkg::TGT_B1) else $error("data block one alias");
   AST_PASSWORD_LOCK: assert property (i_prog_req && i_prog_addr inside {[16'h0040:16'h0043]}
      |=> o_prog_password && !o_prog_write_en) else $error("password word not protected");
   AST_VECTOR_FLAG: assert property (i_prog_req
      |=> o_prog_vector == ($past(i_prog_addr) <= 16'h003F)) else $error("vector flag wrong");
   AST_BOOT_ROUTE: assert property (i_prog_req && ctrl_r[4] && i_prog_addr <= 16'h00FF
      |=> o_prog_target == memory_map_pkg::TGT_BOOT) else $error("boot range not routed");
   AST_LOW_PROG: assert property (i_prog_req && i_prog_addr <= 16'h7FFF
      && !(ctrl_r[4] && i_prog_addr <= 16'h00FF) ##0 ctrl_r[3] |=> o_prog_target
      == memory_map_pkg::TGT_EXT) else $error("external mode not routed outside");
   AST_PROG_SRAM: assert property (i_prog_req && i_prog_addr inside {[16'h8000:16'h87FF]}
      |=> o_prog_target == ($past(ctrl_r[1]) ? memory_map_pkg::TGT_SINGLE_ACCESS_RAM
      : memory_map_pkg::TGT_EXT))
      else $error("program single-access ram route");
   AST_DATA_SRAM: assert property (i_data_req && i_data_addr inside {[16'h0800:16'h0FFF]}
      |=> o_data_target == ($past(ctrl_r[2]) ? memory_map_pkg::TGT_SINGLE_ACCESS_RAM
      : memory_map_pkg::TGT_NONE))
      else $error("data single-access ram route");
   AST_RESERVED_NO_WRITE: assert property (o_data_target == memory_map_pkg::TGT_NONE
      |-> !o_data_write_en) else $error("write enabled on reserved data access");

   COV_PROG_ALIAS: cover property (o_prog_target == memory_map_pkg::TGT_B0);
   COV_BOOT: cover property (o_prog_target == memory_map_pkg::TGT_BOOT);
   COV_DATA_SRAM: cover property (o_data_target == memory_map_pkg::TGT_SINGLE_ACCESS_RAM);
endmodule : memory_map_decoder_assertions

// ===== tb/core_access_model.sv
// Purpose: processor core issuing one program and one data access per cycle
// Assumes: accesses are launched right after a rising edge
// Notes:   an idle address bus shows the inverted last address, never a stale one

`timescale 1ns/10ps

module core_access_model (
   input  wire logic        i_clock,
   output logic             o_prog_req,
   output logic [15:0]      o_prog_addr,
   output logic             o_prog_write,
   output logic             o_data_req,
   output logic [15:0]      o_data_addr,
   output logic             o_data_write
);
   initial begin
      o_prog_req   = 1'b0;
      o_prog_addr  = 16'h0000;
      o_prog_write = 1'b0;
      o_data_req   = 1'b0;
      o_data_addr  = 16'h0000;
      o_data_write = 1'b0;
   end

   task automatic issue(input logic pr, input logic [15:0] pa, input logic pw,
                        input logic dr, input logic [15:0] da, input logic dw);
      @(posedge i_clock);
      o_prog_req   <= pr;
      o_prog_addr  <= pr ? pa : ~o_prog_addr;
      o_prog_write <= pw;
      o_data_req   <= dr;
      o_data_addr  <= dr ? da : ~o_data_addr;
      o_data_write <= dw;
   endtask : issue
endmodule : core_access_model

// ===== tb/memory_map_decoder_tb_top.sv
// Purpose: self-checking bench for the memory map decoder
// Assumes: zero-wait bus slave, decode answered exactly one cycle after the request
// Notes:   every control combination is swept with boundary and random addresses

`timescale 1ns/10ps

module memory_map_decoder_tb_top;
   // -------------------------------------------------------------------
   // signals, design, partner and reference model
   // -------------------------------------------------------------------
   logic i_clock = 1'b0, i_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic i_prog_req, i_prog_write, o_prog_valid, o_prog_write_en, o_prog_vector, o_prog_password;
   logic i_data_req, i_data_write, o_data_valid, o_data_write_en;
   logic [15:0] i_prog_addr, i_data_addr, o_prog_offset, o_data_offset;
   memory_map_pkg::target_t o_prog_target, o_data_target;
   int miscompares = 0, num_checks = 0;
   logic [4:0] ctrl_m = 5'h00;
   logic [19:0] pe, de;
   logic [15:0] hits_m = 16'h0000, hit_a = 16'h0000, da_q;
   logic started = 1'b0, pv, dv, pw, dw, pvec, ppwd;
   logic [15:0] pb [16] = '{16'h0000, 16'h003F, 16'h0040, 16'h0043, 16'h0044, 16'h00FF,
      16'h0100, 16'h7FFF, 16'h8000, 16'h87FF, 16'h8800, 16'hFDFF, 16'hFE00, 16'hFEFF,
      16'hFF00, 16'hFFFF};
   logic [15:0] db [16] = '{16'h005F, 16'h0060, 16'h007F, 16'h0080, 16'h0100, 16'h01FF,
      16'h0200, 16'h02FF, 16'h0300, 16'h04FF, 16'h0500, 16'h0800, 16'h0FFF, 16'h1000,
      16'h7000, 16'h8000};

   always #25 i_clock = ~i_clock;

   memory_map_decoder DUT (.i_clock, .i_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .i_prog_req, .i_prog_addr, .i_prog_write,
      .o_prog_valid, .o_prog_target, .o_prog_offset, .o_prog_write_en, .o_prog_vector,
      .o_prog_password, .i_data_req, .i_data_addr, .i_data_write, .o_data_valid, .o_data_target,
      .o_data_offset, .o_data_write_en);

   core_access_model core (.i_clock, .o_prog_req(i_prog_req), .o_prog_addr(i_prog_addr),
      .o_prog_write(i_prog_write), .o_data_req(i_data_req), .o_data_addr(i_data_addr),
      .o_data_write(i_data_write));

   function automatic logic [19:0] pdec(input logic [15:0] a, input logic [4:0] c);
      if (c[4] && a <= 16'h00FF) return {memory_map_pkg::TGT_BOOT, a};
      if (a <= 16'h7FFF) return {c[3] ? memory_map_pkg::TGT_EXT : memory_map_pkg::TGT_FLASH, a};
      if (a <= 16'h87FF && c[1]) return {memory_map_pkg::TGT_SINGLE_ACCESS_RAM, 5'h00, a[10:0]};
      if (a >= 16'hFE00 && c[0]) return {memory_map_pkg::TGT_B0, 8'h00, a[7:0]};
      return {memory_map_pkg::TGT_EXT, a};
   endfunction : pdec

   function automatic logic [19:0] ddec(input logic [15:0] a, input logic [4:0] c);
      if (a <= 16'h005F) return {memory_map_pkg::TGT_MMR, a};
      if (a <= 16'h007F) return {memory_map_pkg::TGT_B2, 11'h000, a[4:0]};
      if (a inside {[16'h0100:16'h02FF]} && !c[0]) return {memory_map_pkg::TGT_B0, 8'h00, a[7:0]};
      if (a inside {[16'h0300:16'h04FF]}) return {memory_map_pkg::TGT_B1, 8'h00, a[7:0]};
      if (a inside {[16'h0800:16'h0FFF]} && c[2])
         return {memory_map_pkg::TGT_SINGLE_ACCESS_RAM, 5'h00, a[10:0]};
      if (a >= 16'h7000) return {a[15] ? memory_map_pkg::TGT_EXT : memory_map_pkg::TGT_PERIPH, a};
      return {memory_map_pkg::TGT_NONE, a};
   endfunction : ddec

   always @(posedge i_clock) begin
      started <= 1'b1;
      pv <= !i_rst && i_prog_req;
      dv <= !i_rst && i_data_req;
      pe <= pdec(i_prog_addr, ctrl_m);
      de <= ddec(i_data_addr, ctrl_m);
      pw <= i_prog_write;
      dw <= i_data_write;
      pvec <= i_prog_addr <= 16'h003F;
      ppwd <= i_prog_addr inside {[16'h0040:16'h0043]};
      da_q <= i_data_addr;
      if (dv && de[19:16] == 4'h0) begin
         hits_m <= hits_m + 16'h0001;
         hit_a  <= da_q;
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   always @(negedge i_clock) if (started) begin
      check("prog_valid", 32'(o_prog_valid), 32'(pv));
      check("prog_target", 32'(o_prog_target), pv ? 32'(pe[19:16]) : 32'h0);
      check("prog_wen", 32'(o_prog_write_en), 32'(pv && pw && pe[19:16] != 4'h3 && !ppwd));
      if (pv) check("prog_offset", 32'(o_prog_offset), 32'(pe[15:0]));
      if (pv) check("prog_flags", 32'({o_prog_vector, o_prog_password}), 32'({pvec, ppwd}));
      check("data_valid", 32'(o_data_valid), 32'(dv));
      check("data_target", 32'(o_data_target), dv ? 32'(de[19:16]) : 32'h0);
      check("data_wen", 32'(o_data_write_en), 32'(dv && dw && de[19:16] != 4'h0));
      if (dv && de[19:16] != 4'h0)
         check("data_offset", 32'(o_data_offset), 32'(de[15:0]));
      check("hresp", 32'(hresp), 32'h0);
   end

   task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                           output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge i_clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge i_clock); while (hreadyout !== 1'b1);
      rd = hrdata;
      if (w && a == 32'h0) ctrl_m <= wd[4:0];
   endtask : ahb_xfer

   task automatic test_done;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   initial begin
      repeat (30000) @(posedge i_clock);
      miscompares++;
      test_done();
   end

   initial begin
      logic [31:0] rd;
      logic [15:0] pa, da;
      void'($urandom(32'hF743));
      repeat (4) @(posedge i_clock);
      i_rst <= 1'b0;
      ahb_xfer(32'h0, 1'b0, 32'h0, rd);
      check("ctrl_reset", rd, 32'h0);
      ahb_xfer(32'hC, 1'b0, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      // every control combination, while the core keeps its last access up
      for (int c = 0; c < 32; c++) begin
         ahb_xfer(32'h0, 1'b1, 32'(c), rd);
         ahb_xfer(32'h0, 1'b0, 32'h0, rd);
         check("ctrl", rd, 32'(c));
         for (int i = 0; i < 40; i++) begin
            pa = (i < 16) ? pb[i] : 16'($urandom) >> $urandom_range(0, 8);
            da = (i < 16) ? db[i] : 16'($urandom) >> $urandom_range(0, 8);
            core.issue(i < 16 || $urandom_range(0, 7) != 0, pa, 1'($urandom),
                       i < 16 || $urandom_range(0, 7) != 0, da, 1'($urandom));
         end
      end
      core.issue(1'b0, 16'h0000, 1'b0, 1'b0, 16'h0000, 1'b0);
      repeat (3) @(posedge i_clock);
      ahb_xfer(32'h8, 1'b0, 32'h0, rd);
      check("hit_addr", rd, {16'h0000, hit_a});
      ahb_xfer(32'h4, 1'b0, 32'h0, rd);
      check("hit_count", rd, {16'h0000, hits_m});
      ahb_xfer(32'h4, 1'b1, 32'h0, rd);
      ahb_xfer(32'h4, 1'b0, 32'h0, rd);
      check("hit_clear", rd, 32'h0);
      test_done();
   end
endmodule : memory_map_decoder_tb_top

bind memory_map_decoder memory_map_decoder_assertions chk (.i_clock, .i_rst, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .i_prog_req, .i_prog_addr, .o_prog_target, .o_prog_offset,
   .o_prog_write_en, .o_prog_vector, .o_prog_password, .i_data_req, .i_data_addr, .o_data_target,
   .o_data_offset, .o_data_write_en);
